/* File: eeprom_bus_pkg.sv */
// constants and types shared by the serial eeprom bus front end
package eeprom_bus_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned T_WR_US = 5000;
  localparam int unsigned WR_CYC_DEFAULT = T_WR_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // address and field layout
  // ****************************************
  localparam logic [3:0] DEV_MAIN = 4'hA;
  localparam logic [3:0] DEV_SPECIAL = 4'hB;
  localparam logic [2:0] MODULE_CS = 3'h0;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [1:0] IDX_DEV = 2'h0;
  localparam logic [1:0] IDX_HI = 2'h1;
  localparam logic [1:0] IDX_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam logic [1:0] SEL_SECTOR = 2'h0;
  localparam logic [1:0] SEL_UID = 2'h1;
  localparam logic [1:0] SEL_LOCK = 2'h2;
  localparam logic [1:0] SEL_ECC = 2'h3;
  localparam int LOCK_DATA_BIT = 1;
  localparam logic [14:0] MASK_FULL = 15'h7FFF;
  localparam logic [14:0] MASK_PAGE = 15'h003F;
  localparam logic [14:0] MASK_UID = 15'h000F;
  // arbitrary neutral serial number value
  localparam logic [127:0] SERIAL_DEFAULT = 128'h00112233445566778899AABBCCDDEEFF;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] cs;
    logic modv;
  } pins_type;

  localparam pins_type PINS_IDLE = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, cs: 3'h0, modv: 1'b0};

  typedef struct packed {
    logic special;
    logic [1:0] sel;
    logic [14:0] addr;
    logic [7:0] data;
  } mem_req_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_RXACK = 5'h04,
    ST_TX = 5'h08,
    ST_TXACK = 5'h10
  } link_state_type;

endpackage : eeprom_bus_pkg

/* File: serial_eeprom_bus_front_end.sv */
// two-wire serial slave front end of a byte-organised eeprom
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - data changes only with clock low; changes while clock high are start or stop.
// - falling data with clock high is start; traffic ignored until start.
// - rising data with clock high is stop; after a read, enter standby.
// - words are 8 bits; device pulls data low on ninth clock to acknowledge.
// - standby at power-up and after stop once internal work finishes.
// - device address upper nibble 1010 selects main array, 1011 the special areas, else no response.
// - device address bits 3..1 must match the three chip-select pins.
// - module variant fixes the chip-select bits at zero.
// - device address bit 0 high reads, low writes.
// - acknowledge on match; on mismatch no acknowledge and back to standby.
// - upper nibble 1011 selects sector, lock bit, serial number, ecc flag.
// - first word gives array bits 14..8, or special area select bits 2..1.
// - second word gives low address; serial read needs low nibble zero.
// - serial number is read-only; writes are rejected.
// - 64-byte security sector writable until locked, then read-only.
// - one-bit ecc flag tells of single-bit error on read; read only.
// - write-protect high inhibits all programming.
// - write cycle runs from the stop ending a write sequence.
// - write cycle ends within 5 ms after the stop.
// - during write cycle inputs ignored and addresses not acknowledged.
// - with sector locked, sector or lock data bytes are not acknowledged.
module serial_eeprom_bus_front_end
  import eeprom_bus_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYC_DEFAULT,
  parameter logic [127:0] SERIAL_VALUE = SERIAL_DEFAULT
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic chip_select_bit_2_in,
  input wire logic chip_select_bit_1_in,
  input wire logic chip_select_bit_0_in,
  input wire logic module_variant_in,
  input wire logic write_protect_in,
  input wire logic ecc_error_in,
  input wire logic [7:0] rd_data_in,
  output mem_req_type req_out,
  output logic wr_strobe_out,
  output logic busy_out,
  output logic standby_out,
  output logic ecc_single_error_flag_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  pins_type pin_raw;
  pins_type sync1_q;
  pins_type s;
  pins_type p;

  assign pin_raw = '{scl: scl_in, sda: sda_in, wp: write_protect_in,
                     cs: {chip_select_bit_2_in, chip_select_bit_1_in, chip_select_bit_0_in},
                     modv: module_variant_in};

  // two stages, then a third copy for edge finding
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= PINS_IDLE;
      s <= PINS_IDLE;
      p <= PINS_IDLE;
    end else begin
      sync1_q <= pin_raw;
      s <= sync1_q;
      p <= s;
    end
  end

  // ****************************************
  // bus events
  // ****************************************
  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;
  assign scl_rise_w = s.scl & ~p.scl;
  assign scl_fall_w = ~s.scl & p.scl;
  // data edge with clock high
  // clock high on both samples keeps a clock edge from posing as start
  assign start_w = s.scl & p.scl & p.sda & ~s.sda;
  assign stop_w = s.scl & p.scl & ~p.sda & s.sda;

  // ****************************************
  // state
  // ****************************************
  link_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic oe_q, oe_d;
  logic rw_q, rw_d;
  logic special_q, special_d;
  logic [1:0] sel_q, sel_d;
  logic [14:0] addr_q, addr_d;
  logic mack_q, mack_d;
  logic ecc_q, ecc_d;
  logic locked_q;
  logic lock_pend_q;
  logic wr_pend_q;
  logic busy_q;
  logic [19:0] busy_cnt_q;
  logic wr_strobe_q;
  logic standby_q;
  mem_req_type req_q;

  // ****************************************
  // decode
  // ****************************************
  logic [2:0] cs_w;
  logic dev_hit_w;
  logic byte_end_w;
  logic lo_ok_w;
  logic data_ok_w;
  logic ack_ok_w;
  logic program_w;
  logic load_first_w;
  logic load_next_w;
  logic [7:0] rd_byte_w;
  logic [14:0] mask_w;
  logic [14:0] addr_next_w;
  logic commit_w;

  assign cs_w = s.modv ? MODULE_CS : s.cs;
  assign byte_end_w = (st_q == ST_RX) & scl_fall_w & (cnt_q == BITS_PER_WORD);
  assign dev_hit_w = ((sh_q[7:4] == DEV_MAIN) | (sh_q[7:4] == DEV_SPECIAL))
                     & (sh_q[3:1] == cs_w) & ~busy_q;
  // serial read starts on a zero nibble
  assign lo_ok_w = ~(special_q & (sel_q == SEL_UID) & (sh_q[3:0] != 4'h0));
  // serial and ecc areas refuse data
  assign data_ok_w = ~rw_q & (~special_q
                     | ((sel_q == SEL_SECTOR) & ~locked_q)
                     | ((sel_q == SEL_LOCK) & ~locked_q));
  assign ack_ok_w = (idx_q == IDX_DEV) ? dev_hit_w :
                    (idx_q == IDX_LO) ? lo_ok_w :
                    (idx_q == IDX_DATA) ? data_ok_w : 1'b1;
  assign program_w = byte_end_w & (idx_q == IDX_DATA) & data_ok_w & ~s.wp;
  assign load_first_w = (st_q == ST_RXACK) & scl_fall_w & (idx_q == IDX_DEV) & rw_q;
  assign load_next_w = (st_q == ST_TXACK) & scl_fall_w & mack_q;
  assign commit_w = stop_w & wr_pend_q;

  // read source by area
  assign rd_byte_w = ~special_q ? rd_data_in :
                     (sel_q == SEL_UID) ? SERIAL_VALUE[{addr_q[3:0], 3'h0} +: 8] :
                     (sel_q == SEL_LOCK) ? {6'h00, locked_q, 1'b0} :
                     (sel_q == SEL_ECC) ? {7'h00, ecc_q} : rd_data_in;

  // writes roll in the page, reads roll over the whole area
  assign mask_w = ~rw_q ? MASK_PAGE :
                  ~special_q ? MASK_FULL :
                  (sel_q == SEL_UID) ? MASK_UID : MASK_PAGE;
  assign addr_next_w = (15'(addr_q + 15'h0001) & mask_w) | (addr_q & ~mask_w);

  // ****************************************
  // link state machine
  // ****************************************
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    sh_d = sh_q;
    tx_d = tx_q;
    oe_d = oe_q;
    rw_d = rw_q;
    special_d = special_q;
    sel_d = sel_q;
    addr_d = addr_q;
    mack_d = mack_q;
    ecc_d = ecc_q;
    if (start_w) begin
      // start also ends any stuck transfer
      st_d = ST_RX;
      cnt_d = 4'h0;
      idx_d = IDX_DEV;
      oe_d = 1'b0;
    end else if (stop_w) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (scl_rise_w && cnt_q < BITS_PER_WORD) begin
            sh_d = {sh_q[6:0], s.sda};
            cnt_d = 4'(cnt_q + 4'h1);
          end else if (byte_end_w) begin
            if (ack_ok_w) begin
              st_d = ST_RXACK;
              oe_d = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
            if (idx_q == IDX_DEV) begin
              rw_d = sh_q[0];
              special_d = (sh_q[7:4] == DEV_SPECIAL);
            end else if (idx_q == IDX_HI) begin
              // high address or area select
              // special areas keep a clean index so the store sees no stale high bits
              sel_d = special_q ? sh_q[2:1] : SEL_SECTOR;
              addr_d[14:8] = special_q ? 7'h00 : sh_q[6:0];
            end else if (idx_q == IDX_LO) begin
              // low address, sector index is six bits
              addr_d[7:0] = special_q ? {2'b00, sh_q[5:0]} : sh_q;
            end
          end
        end
        ST_RXACK: begin
          if (scl_fall_w) begin
            cnt_d = 4'h0;
            idx_d = (idx_q == IDX_DATA) ? IDX_DATA : 2'(idx_q + 2'h1);
            if (idx_q == IDX_DATA) begin
              addr_d = addr_next_w;
            end
            if (load_first_w) begin
              st_d = ST_TX;
              tx_d = rd_byte_w;
              oe_d = ~rd_byte_w[7];
              addr_d = addr_next_w;
            end else begin
              st_d = ST_RX;
              oe_d = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall_w) begin
            if (cnt_q == TX_LAST_BIT) begin
              st_d = ST_TXACK;
              oe_d = 1'b0;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_q[6];
              cnt_d = 4'(cnt_q + 4'h1);
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise_w) begin
            mack_d = ~s.sda;
          end else if (load_next_w) begin
            st_d = ST_TX;
            cnt_d = 4'h0;
            tx_d = rd_byte_w;
            oe_d = ~rd_byte_w[7];
            addr_d = addr_next_w;
          end else if (scl_fall_w) begin
            st_d = ST_IDLE;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end
    // flag follows each main array byte sent
    if ((load_first_w || load_next_w) && !special_q) begin
      ecc_d = ecc_error_in;
    end
  end

  // link registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      idx_q <= IDX_DEV;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      special_q <= 1'b0;
      sel_q <= SEL_SECTOR;
      addr_q <= 15'h0000;
      mack_q <= 1'b0;
      ecc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      special_q <= special_d;
      sel_q <= sel_d;
      addr_q <= addr_d;
      mack_q <= mack_d;
      ecc_q <= ecc_d;
    end
  end

  // ****************************************
  // write cycle and lock
  // ****************************************
  // lock takes effect when the write cycle starts
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_pend_q <= 1'b0;
      lock_pend_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      wr_pend_q <= ~start_w & ~stop_w & (wr_pend_q | program_w);
      lock_pend_q <= ~start_w & ~stop_w & (lock_pend_q | (program_w & special_q
                     & (sel_q == SEL_LOCK) & sh_q[LOCK_DATA_BIT]));
      locked_q <= locked_q | (stop_w & lock_pend_q);
    end
  end

  // bounded by the write cycle count
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy_q <= 1'b0;
      busy_cnt_q <= 20'h00000;
    end else if (commit_w) begin
      busy_q <= 1'b1;
      busy_cnt_q <= 20'(WR_CYCLES - 1);
    end else if (busy_q) begin
      busy_q <= (busy_cnt_q != 20'h00000);
      busy_cnt_q <= 20'(busy_cnt_q - 20'h00001);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // standby at reset and when idle and not busy
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      standby_q <= 1'b1;
      wr_strobe_q <= 1'b0;
      req_q <= '0;
    end else begin
      standby_q <= (st_d == ST_IDLE) & ~commit_w & ~(busy_q & (busy_cnt_q != 20'h00000));
      wr_strobe_q <= program_w;
      req_q <= '{special: special_d, sel: sel_d, addr: addr_d, data: sh_q};
    end
  end

  assign sda_out = 1'b0; // open drain, only ever pulls low
  assign sda_oe_out = oe_q;
  assign req_out = req_q;
  assign wr_strobe_out = wr_strobe_q;
  assign busy_out = busy_q;
  assign standby_out = standby_q;
  assign ecc_single_error_flag_out = ecc_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [19:0] busy_len_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy_len_q <= 20'h00000;
    end else begin
      busy_len_q <= busy_q ? 20'(busy_len_q + 20'h00001) : 20'h00000;
    end
  end

  a_start_opens: assert property (start_w |=> st_q == ST_RX && cnt_q == 4'h0)
    else $error("start did not open a byte");
  a_stop_idles: assert property (stop_w |=> st_q == ST_IDLE && !sda_oe_out)
    else $error("stop did not idle the link");
  a_ack_low: assert property (byte_end_w && ack_ok_w && !start_w && !stop_w |=> sda_oe_out)
    else $error("no acknowledge after a good byte");
  a_miss_nack: assert property (byte_end_w && idx_q == IDX_DEV && !dev_hit_w && !stop_w
    |=> st_q == ST_IDLE && !sda_oe_out)
    else $error("address mismatch was acknowledged");
  a_busy_nack: assert property (byte_end_w && idx_q == IDX_DEV && busy_q |=> !sda_oe_out)
    else $error("address acknowledged during write cycle");
  a_wp_blocks: assert property (wr_strobe_out |-> !$past(s.wp))
    else $error("programming under write protect");
  a_serial_ro: assert property (wr_strobe_out |-> !(req_out.special && req_out.sel[0]))
    else $error("write strobe to a read-only area");
  a_busy_cause: assert property ($rose(busy_q) |-> $past(stop_w) && $past(wr_pend_q))
    else $error("write cycle without a terminating stop");
  a_busy_max: assert property (busy_q |-> busy_len_q < 20'(WR_CYCLES))
    else $error("write cycle longer than allowed");
  a_ack_release: assert property (st_q == ST_RXACK && scl_fall_w && !load_first_w && !start_w
    && !stop_w |=> !sda_oe_out)
    else $error("data line held after acknowledge");
  a_standby_rst: assert property (st_q == ST_IDLE && !busy_q && !start_w |=> standby_out)
    else $error("idle link not in standby");
  a_lock_nack: assert property (byte_end_w && idx_q == IDX_DATA && special_q && locked_q
    && !sel_q[0] && !stop_w |=> !sda_oe_out)
    else $error("locked sector data acknowledged");

  c_write_cycle: cover property ($rose(busy_q));
  c_read_byte: cover property (load_first_w);
  c_seq_read: cover property (load_next_w);
  c_lock_set: cover property ($rose(locked_q));

endmodule : serial_eeprom_bus_front_end
`default_nettype wire

/* File: eeprom_bus_master.sv */
// two-wire bus master model that drives the eeprom front end
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // quarter of the 160 ns link period, in system clocks
  localparam int Q = 4;

  // bus idles released; the link clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  task automatic bit_cycle(input logic low, output logic seen);
    sda_low_out = low;
    tick(Q);
    scl_out = 1'b1;
    tick(2 * Q);
    seen = sda_in;
    scl_out = 1'b0;
    tick(Q);
  endtask : bit_cycle

  task automatic start_c();
    sda_low_out = 1'b0;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    sda_low_out = 1'b1;
    tick(Q);
    scl_out = 1'b0;
    tick(Q);
  endtask : start_c

  task automatic stop_c();
    sda_low_out = 1'b1;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    sda_low_out = 1'b0;
    tick(2 * Q);
  endtask : stop_c

  // up to nine clocks, then start
  task automatic recover();
    logic s;
    s = 1'b0;
    scl_out = 1'b0;
    tick(Q);
    for (int i = 0; i < 9 && !s; i++) bit_cycle(1'b0, s);
    start_c();
  endtask : recover

  // msb first; the ninth clock carries the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(~b[i], s);
    bit_cycle(1'b0, s);
    ack = ~s;
  endtask : put_byte

  task automatic get_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, s);
      b[i] = s;
    end
    bit_cycle(ack_it, s);
  endtask : get_byte
endmodule : eeprom_bus_master
`default_nettype wire

/* File: serial_eeprom_bus_front_end_bench.sv */
// self-checking bench for the serial eeprom bus front end
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_front_end_bench;
  import eeprom_bus_pkg::*;
  // short write cycle keeps the run brief but outlasts one poll byte
  localparam int unsigned WR_CYC = 400;
  logic clk_in, sys_rst_in, scl, m_low, oe, drv, wp, modv, ecc_err, wr_strobe, busy, standby, flag;
  logic [2:0] cs;
  logic [7:0] rd_data;
  logic [3:0] acks;
  logic [15:0] rd2;
  logic [31:0] seed;
  mem_req_type req, last_req;
  int failures, n_checks, n_strobe, busy_len;
  // pull-up wire shared by master and device
  wire logic sda = ~m_low & (oe ? drv : 1'b1);

  serial_eeprom_bus_front_end #(.WR_CYCLES(WR_CYC)) serial_eeprom_bus_front_end_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda), .sda_out(drv), .sda_oe_out(oe),
    .chip_select_bit_2_in(cs[2]), .chip_select_bit_1_in(cs[1]), .chip_select_bit_0_in(cs[0]),
    .module_variant_in(modv), .write_protect_in(wp), .ecc_error_in(ecc_err), .rd_data_in(rd_data),
    .req_out(req), .wr_strobe_out(wr_strobe), .busy_out(busy), .standby_out(standby),
    .ecc_single_error_flag_out(flag));
  eeprom_bus_master eeprom_bus_master_inst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));

  // ****************************************
  // clock, memory image and monitors
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [7:0] mem_byte(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3C;
  endfunction : mem_byte

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  always @(negedge clk_in) rd_data <= mem_byte(req.addr);
  // strobes and busy cycles are counted where the design makes them
  always @(posedge clk_in) begin
    if (wr_strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
      last_req <= req;
    end
    if (busy === 1'b1) busy_len <= busy_len + 1;
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // bounded wait for the end of any write cycle
  task automatic wait_idle();
    int i;
    for (i = 0; i < 1000 && !(standby === 1'b1 && busy === 1'b0); i++) @(negedge clk_in);
    if (i == 1000) begin
      failures++;
      stop_test();
    end
  endtask : wait_idle

  task automatic addr3(input logic [3:0] nib, input logic [7:0] hi, input logic [7:0] lo);
    eeprom_bus_master_inst.start_c();
    eeprom_bus_master_inst.put_byte({nib, cs, 1'b0}, acks[3]);
    eeprom_bus_master_inst.put_byte(hi, acks[2]);
    eeprom_bus_master_inst.put_byte(lo, acks[1]);
  endtask : addr3

  task automatic wr(input logic [3:0] nib, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d);
    addr3(nib, hi, lo);
    eeprom_bus_master_inst.put_byte(d, acks[0]);
    eeprom_bus_master_inst.stop_c();
  endtask : wr

  // dummy write, restart, two bytes with the second left unacknowledged
  task automatic rd(input logic [3:0] nib, input logic [7:0] hi, input logic [7:0] lo);
    addr3(nib, hi, lo);
    eeprom_bus_master_inst.start_c();
    eeprom_bus_master_inst.put_byte({nib, cs, 1'b1}, acks[0]);
    eeprom_bus_master_inst.get_byte(1'b1, rd2[15:8]);
    eeprom_bus_master_inst.get_byte(1'b0, rd2[7:0]);
    eeprom_bus_master_inst.stop_c();
  endtask : rd

  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    stop_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n0;
    logic a;
    sys_rst_in = 1'b1;
    wp = 1'b0;
    modv = 1'b0;
    ecc_err = 1'b0;
    cs = 3'h5;
    rd_data = 8'h00;
    seed = 32'h38CD;
    failures = 0;
    n_checks = 0;
    n_strobe = 0;
    busy_len = 0;
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    check("standby", standby, 32'h1);
    check("oe", {busy, oe, flag, wr_strobe, req}, 32'h0);
    // hold off the first command for 100 us
    repeat (10000) @(negedge clk_in);
    eeprom_bus_master_inst.recover();
    // random main-array writes, each polled while busy
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      cs = seed[2:0];
      n0 = n_strobe;
      busy_len = 0;
      wr(DEV_MAIN, seed[15:8], seed[23:16], seed[31:24]);
      check("acks", acks, 32'hF);
      check("strobes", n_strobe, n0 + 1);
      check("req", last_req, {1'b0, 2'b00, seed[14:8], seed[23:16], seed[31:24]});
      check("busy", {busy, standby}, 32'h2);
      eeprom_bus_master_inst.start_c();
      eeprom_bus_master_inst.put_byte({DEV_MAIN, cs, 1'b0}, a);
      check("poll", a, 32'h0);
      eeprom_bus_master_inst.stop_c();
      wait_idle();
      check("wr_len", busy_len, WR_CYC);
    end
    // foreign nibble and wrong select bits stay silent
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      eeprom_bus_master_inst.start_c();
      eeprom_bus_master_inst.put_byte({1'b0, seed[2:0], cs, seed[4]}, a);
      check("nibble", a, 32'h0);
      eeprom_bus_master_inst.start_c();
      eeprom_bus_master_inst.put_byte({DEV_MAIN, cs ^ {seed[6:5], 1'b1}, seed[4]}, a);
      check("select", a, 32'h0);
      check("stby", standby, 32'h1);
    end
    // module variant answers only select bits 000
    modv = 1'b1;
    cs = 3'h6;
    eeprom_bus_master_inst.start_c();
    eeprom_bus_master_inst.put_byte({DEV_MAIN, 3'h0, 1'b0}, a);
    check("mod0", a, 32'h1);
    eeprom_bus_master_inst.start_c();
    eeprom_bus_master_inst.put_byte({DEV_MAIN, 3'h6, 1'b0}, a);
    check("mod6", a, 32'h0);
    eeprom_bus_master_inst.stop_c();
    modv = 1'b0;
    // write protect: acknowledged yet nothing programmed
    wp = 1'b1;
    n0 = n_strobe;
    wr(DEV_MAIN, seed[15:8], seed[23:16], seed[31:24]);
    check("wp_ack", acks, 32'hF);
    check("wp_str", {n_strobe[30:0], busy}, {n0[30:0], 1'b0});
    wp = 1'b0;
    // sequential main read with an ecc event, then the flag area
    seed = xs(seed);
    ecc_err = 1'b1;
    rd(DEV_MAIN, seed[15:8], seed[23:16]);
    ecc_err = 1'b0;
    check("rd_ack", acks, 32'hF);
    check("rd", rd2, {mem_byte({seed[14:8], seed[23:16]}), mem_byte({seed[14:8], seed[23:16]} + 15'h1)});
    check("flag", flag, 32'h1);
    check("rd_stby", standby, 32'h1);
    rd(DEV_SPECIAL, {seed[7:3], 2'b11, seed[0]}, seed[31:24]);
    check("ecc_rd", rd2[15:8], 32'h1);
    // serial number read, then a refused nonzero nibble
    rd(DEV_SPECIAL, {seed[7:3], 2'b01, seed[0]}, {seed[15:12], 4'h0});
    check("serial", rd2, {SERIAL_DEFAULT[7:0], SERIAL_DEFAULT[15:8]});
    rd(DEV_SPECIAL, 8'h02, {seed[15:12], seed[11:8] | 4'h1});
    check("ser_nib", acks[3:1], 32'h6);
    // data to read-only areas is refused
    n0 = n_strobe;
    wr(DEV_SPECIAL, 8'h02, 8'h00, seed[7:0]);
    check("ser_wr", acks, 32'hE);
    wr(DEV_SPECIAL, 8'h06, 8'h00, seed[7:0]);
    check("ecc_wr", {acks, n_strobe[27:0]}, {4'hE, n0[27:0]});
    // security sector write, lock, then refusals
    wr(DEV_SPECIAL, 8'h00, 8'h05, seed[7:0]);
    wait_idle();
    check("sec_req", last_req, {1'b1, SEL_SECTOR, 15'h0005, seed[7:0]});
    rd(DEV_SPECIAL, 8'h00, 8'h05);
    check("sec_rd", rd2, {mem_byte(15'h5), mem_byte(15'h6)});
    wr(DEV_SPECIAL, 8'h04, seed[15:8], 8'h02);
    wait_idle();
    check("lock_ack", acks, 32'hF);
    rd(DEV_SPECIAL, 8'h04, 8'h00);
    check("lock_rd", rd2[15:8], 32'h2);
    n0 = n_strobe;
    wr(DEV_SPECIAL, 8'h00, 8'h07, seed[7:0]);
    check("sec_lkd", acks, 32'hE);
    wr(DEV_SPECIAL, 8'h04, 8'h00, 8'h02);
    check("lock_lkd", {acks, n_strobe[27:0]}, {4'hE, n0[27:0]});
    stop_test();
  end
endmodule : serial_eeprom_bus_front_end_bench
`default_nettype wire
